/* src/als_timing_pkg.sv */
// Constants shared by the light sensor enable and timing control logic
package als_timing_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] FUNCTION_ENABLES_ADDR   = 8'h80;
  localparam logic [7:0] INTEGRATION_LENGTH_ADDR = 8'h81;
  localparam logic [7:0] WAIT_LENGTH_ADDR        = 8'h83;
  localparam logic [7:0] CONFIG_ZERO_ADDR        = 8'h8D;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] FUNCTION_ENABLES_RESET   = 8'h00;
  localparam logic [7:0] INTEGRATION_LENGTH_RESET = 8'h00;
  localparam logic [7:0] WAIT_LENGTH_RESET        = 8'h00;
  localparam logic [7:0] CONFIG_ZERO_RESET        = 8'h80;
  localparam logic [7:0] UNMAPPED_READ_VALUE      = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int POWER_ON_BIT_POS         = 0;
  localparam int LIGHT_MEASURE_ON_POS     = 1;
  localparam int WAIT_ENABLE_POS          = 3;
  localparam int WAIT_TIMES_TWELVE_POS    = 2;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int SYS_CLK_MHZ              = 125;
  localparam int OSC_MHZ                  = 8;
  localparam int OSC_PER_INT_CLK          = 11;
  localparam int INT_CLKS_PER_STEP        = 2048;
  localparam logic [3:0] LONG_WAIT_EXTRA  = 4'h000B;
  localparam logic [6:0] PHASE_MODULUS    = 7'(SYS_CLK_MHZ);
  localparam logic [6:0] PHASE_INCREMENT  = 7'(OSC_MHZ);

  // ----------------------------------------------------------------------
  // Full scale
  // ----------------------------------------------------------------------
  localparam logic [7:0]  FULL_SCALE_SAT_STEPS = 8'h3F;
  localparam logic [15:0] FULL_SCALE_MAX       = 16'hFFFF;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_SLEEP   = 2'b00,
    ST_IDLE    = 2'b01,
    ST_MEASURE = 2'b10,
    ST_WAIT    = 2'b11
  } seq_state_t;

endpackage

/* src/als_step_timer.sv */
// Oscillator model and divider chain producing one pulse per timing step
`timescale 1ns/1ps
module als_step_timer #(
  parameter int OSC_DIV      = als_timing_pkg::OSC_PER_INT_CLK,
  parameter int INT_PER_STEP = als_timing_pkg::INT_CLKS_PER_STEP
) (
  // Clock, reset, enable
  input  wire logic sys_clk_in,
  input  wire logic reset_n_in,
  input  wire logic clk_en_in,
  // Control
  input  wire logic osc_run_in,
  input  wire logic restart_in,
  // Step pulse
  output logic      step_tick_out
);

  logic [6:0]  phase;
  logic [3:0]  osc_count;
  logic [11:0] int_count;
  logic [6:0]  next_phase;
  logic [7:0]  phase_sum;
  logic [3:0]  next_osc_count;
  logic [11:0] next_int_count;
  logic        next_step_tick;
  logic        osc_tick;
  logic        int_tick;

  // ----------------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------------
  always_comb begin
    phase_sum      = 8'(phase) + 8'(als_timing_pkg::PHASE_INCREMENT);
    next_phase     = phase;
    next_osc_count = osc_count;
    next_int_count = int_count;
    next_step_tick = 1'b0;
    osc_tick       = 1'b0;
    int_tick       = 1'b0;
    if (!osc_run_in || restart_in) begin // RULE3
      next_phase     = '0;
      next_osc_count = '0;
      next_int_count = '0;
    end else begin
      // Average 8 MHz ticks from the 125 MHz clock
      // Sum one bit wider, so no wrap before the compare
      if (phase_sum >= 8'(als_timing_pkg::PHASE_MODULUS)) begin // RULE8
        next_phase = 7'(phase_sum - 8'(als_timing_pkg::PHASE_MODULUS));
        osc_tick   = 1'b1;
      end else begin
        next_phase = phase_sum[6:0];
      end
      if (osc_tick) begin
        if (osc_count == 4'(OSC_DIV - 1)) begin // RULE9
          next_osc_count = '0;
          int_tick       = 1'b1;
        end else begin
          next_osc_count = 4'(osc_count + 4'h0001);
        end
      end
      if (int_tick) begin
        if (int_count == 12'(INT_PER_STEP - 1)) begin // RULE10
          next_int_count = '0;
          next_step_tick = 1'b1;
        end else begin
          next_int_count = 12'(int_count + 12'h0001);
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase         <= '0;
      osc_count     <= '0;
      int_count     <= '0;
      step_tick_out <= 1'b0;
    end else if (clk_en_in) begin
      phase         <= next_phase;
      osc_count     <= next_osc_count;
      int_count     <= next_int_count;
      step_tick_out <= next_step_tick;
    end
  end

endmodule // als_step_timer

/* src/als_enable_and_timing_control.sv */
// Enable registers and measurement/wait sequencer of the light sensor
`timescale 1ns/1ps
// What this block does
// RULE1 - Enable bit 3 switches on the wait phase between measurements and resets to zero.
// RULE2 - Enable bit 1 switches on light measurement and resets to zero.
// RULE3 - Enable bit 0 powers the oscillator and converters and resets to zero.
// RULE4 - The host should set measurement and power enables in one write so autozero runs first.
// RULE5 - The host programs all mode settings before setting the measurement enable.
// RULE6 - Integration is timed by a down counter ending at zero, one count per 2.8 ms step.
// RULE7 - Integration lasts the programmed value plus one steps.
// RULE8 - Timing comes from an oscillator of nominally 8 MHz.
// RULE9 - The oscillator is divided by 11 into the integration clock.
// RULE10 - One step is 2048 integration clock cycles.
// RULE11 - The wait is timed by a down counter lasting the programmed value plus one steps.
// RULE12 - The long-wait bit multiplies the wait by 12.
// RULE13 - Full scale is 1024 per step minus one, saturating at 65535 from 64 steps.
// RULE14 - Setting power leaves sleep for idle and clearing it returns to sleep.
// RULE15 - With power and measurement on, measure phases repeat, with a wait phase after each only when enable bit 3 is set.
module als_enable_and_timing_control #(
  parameter int OSC_DIV      = als_timing_pkg::OSC_PER_INT_CLK,
  parameter int INT_PER_STEP = als_timing_pkg::INT_CLKS_PER_STEP
) (
  // Clock, reset, enable
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        clk_en_in,
  // Register port from the serial target
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_rd_in,
  output logic [7:0]       reg_rdata_out,
  // Sequencer status
  output logic [1:0]       seq_state_out,
  output logic             osc_run_out,
  output logic             integrating_out,
  output logic             meas_done_out,
  output logic [15:0]      full_scale_out
);

  logic [7:0]                     function_enables;
  logic [7:0]                     integration_length;
  logic [7:0]                     wait_length;
  logic [7:0]                     config_zero;
  logic [7:0]                     next_function_enables;
  logic [7:0]                     next_integration_length;
  logic [7:0]                     next_wait_length;
  logic [7:0]                     next_config_zero;
  logic [7:0]                     next_reg_rdata;
  als_timing_pkg::seq_state_t     state;
  als_timing_pkg::seq_state_t     next_state;
  logic [7:0]                     step_count;
  logic [7:0]                     next_step_count;
  logic [3:0]                     long_count;
  logic [3:0]                     next_long_count;
  logic                           restart;
  logic                           next_restart;
  logic                           next_meas_done;
  logic [15:0]                    next_full_scale;
  logic                           step_tick;
  logic                           power_on_bit;
  logic                           light_measure_on;
  logic                           wait_enable;
  logic                           wait_times_twelve;

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  always_comb begin
    next_function_enables   = function_enables;
    next_integration_length = integration_length;
    next_wait_length        = wait_length;
    next_config_zero        = config_zero;
    next_reg_rdata          = reg_rdata_out;
    if (reg_wr_in) begin
      case (reg_addr_in)
        als_timing_pkg::FUNCTION_ENABLES_ADDR: begin
          next_function_enables = reg_wdata_in; // RULE4
        end
        als_timing_pkg::INTEGRATION_LENGTH_ADDR: begin
          next_integration_length = reg_wdata_in;
        end
        als_timing_pkg::WAIT_LENGTH_ADDR: begin
          next_wait_length = reg_wdata_in;
        end
        als_timing_pkg::CONFIG_ZERO_ADDR: begin
          next_config_zero = reg_wdata_in;
        end
        default: begin
          next_config_zero = config_zero;
        end
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        als_timing_pkg::FUNCTION_ENABLES_ADDR:   next_reg_rdata = function_enables;
        als_timing_pkg::INTEGRATION_LENGTH_ADDR: next_reg_rdata = integration_length;
        als_timing_pkg::WAIT_LENGTH_ADDR:        next_reg_rdata = wait_length;
        als_timing_pkg::CONFIG_ZERO_ADDR:        next_reg_rdata = config_zero;
        default:                                 next_reg_rdata = als_timing_pkg::UNMAPPED_READ_VALUE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      function_enables   <= als_timing_pkg::FUNCTION_ENABLES_RESET; // RULE1 RULE2 RULE3
      integration_length <= als_timing_pkg::INTEGRATION_LENGTH_RESET;
      wait_length        <= als_timing_pkg::WAIT_LENGTH_RESET;
      config_zero        <= als_timing_pkg::CONFIG_ZERO_RESET;
      reg_rdata_out      <= als_timing_pkg::UNMAPPED_READ_VALUE;
    end else if (clk_en_in) begin
      function_enables   <= next_function_enables;
      integration_length <= next_integration_length;
      wait_length        <= next_wait_length;
      config_zero        <= next_config_zero;
      reg_rdata_out      <= next_reg_rdata;
    end
  end

  assign power_on_bit      = function_enables[als_timing_pkg::POWER_ON_BIT_POS];     // RULE3
  assign light_measure_on  = function_enables[als_timing_pkg::LIGHT_MEASURE_ON_POS]; // RULE2
  assign wait_enable       = function_enables[als_timing_pkg::WAIT_ENABLE_POS];      // RULE1
  assign wait_times_twelve = config_zero[als_timing_pkg::WAIT_TIMES_TWELVE_POS];

  // ----------------------------------------------------------------------
  // Step timer
  // ----------------------------------------------------------------------
  als_step_timer #(
    .OSC_DIV      (OSC_DIV),
    .INT_PER_STEP (INT_PER_STEP)
  ) u_step_timer (
    .sys_clk_in    (sys_clk_in),
    .reset_n_in    (reset_n_in),
    .clk_en_in     (clk_en_in),
    .osc_run_in    (osc_run_out),
    .restart_in    (restart),
    .step_tick_out (step_tick)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_step_count = step_count;
    next_long_count = long_count;
    next_restart    = 1'b0;
    next_meas_done  = 1'b0;
    case (state)
      als_timing_pkg::ST_SLEEP: begin
        if (power_on_bit) begin // RULE14
          next_state = als_timing_pkg::ST_IDLE;
        end
      end
      als_timing_pkg::ST_IDLE: begin
        if (light_measure_on) begin // RULE15
          next_state      = als_timing_pkg::ST_MEASURE;
          next_step_count = integration_length; // RULE7
          next_restart    = 1'b1;
        end
      end
      als_timing_pkg::ST_MEASURE: begin
        // Drop a tick left over from before the restart
        if (step_tick && !restart) begin
          if (step_count == 8'h00) begin // RULE6
            next_meas_done = 1'b1;
            next_restart   = 1'b1;
            if (wait_enable) begin // RULE1
              next_state      = als_timing_pkg::ST_WAIT;
              next_step_count = wait_length; // RULE11
              next_long_count = wait_times_twelve ? als_timing_pkg::LONG_WAIT_EXTRA : 4'h0000;
            end else begin
              next_step_count = integration_length; // RULE15
            end
          end else begin
            next_step_count = 8'(step_count - 8'h01); // RULE6
          end
        end
      end
      als_timing_pkg::ST_WAIT: begin
        if (step_tick && !restart) begin
          if (long_count != 4'h0000) begin // RULE12
            next_long_count = 4'(long_count - 4'h0001);
          end else if (step_count == 8'h00) begin // RULE11
            next_state      = als_timing_pkg::ST_MEASURE; // RULE15
            next_step_count = integration_length;
            next_restart    = 1'b1;
          end else begin
            next_step_count = 8'(step_count - 8'h01);
            next_long_count = wait_times_twelve ? als_timing_pkg::LONG_WAIT_EXTRA : 4'h0000;
          end
        end
      end
      default: begin
        next_state = als_timing_pkg::ST_SLEEP;
      end
    endcase
    if (!power_on_bit) begin // RULE14
      next_state = als_timing_pkg::ST_SLEEP;
    end else if (!light_measure_on && state != als_timing_pkg::ST_SLEEP) begin
      next_state = als_timing_pkg::ST_IDLE;
    end
  end

  // Full scale of the current integration length
  always_comb begin
    if (integration_length >= als_timing_pkg::FULL_SCALE_SAT_STEPS) begin // RULE13
      next_full_scale = als_timing_pkg::FULL_SCALE_MAX;
    end else begin
      next_full_scale = {integration_length[5:0], 10'h03FF}; // RULE13
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state           <= als_timing_pkg::ST_SLEEP;
      step_count      <= 8'h00;
      long_count      <= 4'h0000;
      restart         <= 1'b0;
      meas_done_out   <= 1'b0;
      seq_state_out   <= 2'h0;
      osc_run_out     <= 1'b0;
      integrating_out <= 1'b0;
      full_scale_out  <= 16'h03FF;
    end else if (clk_en_in) begin
      state           <= next_state;
      step_count      <= next_step_count;
      long_count      <= next_long_count;
      restart         <= next_restart;
      meas_done_out   <= next_meas_done;
      seq_state_out   <= next_state;
      osc_run_out     <= power_on_bit; // RULE3
      integrating_out <= (next_state == als_timing_pkg::ST_MEASURE);
      full_scale_out  <= next_full_scale;
    end
  end

endmodule // als_enable_and_timing_control

/* dv/als_enable_and_timing_control_checker.sv */
// Port checker of the light sensor enable and timing control
`timescale 1ns/1ps
module als_enable_and_timing_control_checker #(
  parameter int OSC_DIV      = als_timing_pkg::OSC_PER_INT_CLK,
  parameter int INT_PER_STEP = als_timing_pkg::INT_CLKS_PER_STEP
) (
  // Clock, reset, enable
  input wire logic        sys_clk_in,
  input wire logic        reset_n_in,
  input wire logic        clk_en_in,
  // Register port
  input wire logic [7:0]  reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_rdata_out,
  // Status
  input wire logic [1:0]  seq_state_out,
  input wire logic        osc_run_out,
  input wire logic        integrating_out,
  input wire logic        meas_done_out,
  input wire logic [15:0] full_scale_out
);
  // ----------------------------------------------------------------------
  // Register shadows and phase counter
  // ----------------------------------------------------------------------
  localparam int STEPC = OSC_DIV * INT_PER_STEP * 125 / 8;
  logic [7:0]  en_q;
  logic [7:0]  int_q;
  logic [31:0] meas_cnt;
  logic        wr_ok;
  assign wr_ok = reg_wr_in && clk_en_in;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      en_q     <= 8'h00;
      int_q    <= 8'h00;
      meas_cnt <= 32'h0000_0000;
    end else begin
      if (wr_ok && reg_addr_in == als_timing_pkg::FUNCTION_ENABLES_ADDR) en_q <= reg_wdata_in;
      if (wr_ok && reg_addr_in == als_timing_pkg::INTEGRATION_LENGTH_ADDR) int_q <= reg_wdata_in;
      meas_cnt <= (integrating_out && !meas_done_out) ? meas_cnt + 1 : 32'h0000_0000;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  chk_power_wakes_idle: assert property (
    seq_state_out == 2'd0 && en_q[0] && clk_en_in |-> ##[1:2] seq_state_out == 2'd1)
    else $error("power set but sequencer stayed asleep");
  chk_unpowered_sleeps: assert property (!en_q[0] [*3] |-> seq_state_out == 2'd0)
    else $error("sequencer awake without power");
  chk_osc_follows_power: assert property (
    $past(clk_en_in) |-> osc_run_out == $past(en_q[0]))
    else $error("oscillator run does not follow power bit");
  chk_integrating_state: assert property (integrating_out == (seq_state_out == 2'd2))
    else $error("integrating flag disagrees with state");
  chk_done_one_pulse: assert property (meas_done_out |=> !meas_done_out)
    else $error("measurement done longer than one cycle");
  chk_done_after_meas: assert property (
    meas_done_out |-> $past(integrating_out) || $past(integrating_out, 2))
    else $error("measurement done outside a measurement");
  chk_full_scale_value: assert property (
    $stable(int_q) && int_q == $past(int_q, 2) |->
    full_scale_out == (int_q >= 8'h3F ? 16'hFFFF : {int_q[5:0], 10'h3FF}))
    else $error("full scale wrong for integration length");
  chk_meas_not_long: assert property (
    meas_cnt <= (32'(int_q) + 1) * STEPC + 3)
    else $error("measurement phase too long");
  chk_meas_not_short: assert property (
    meas_done_out |-> meas_cnt + 4 >= (32'(int_q) + 1) * STEPC)
    else $error("measurement phase too short");
endmodule // als_enable_and_timing_control_checker

/* dv/als_host_model.sv */
// Host model driving the register port of the light sensor block
`timescale 1ns/1ps
module als_host_model (
  // Clock
  input  wire logic       sys_clk_in,
  // Register port
  output logic [7:0]      reg_addr_out,
  output logic            reg_wr_out,
  output logic [7:0]      reg_wdata_out,
  output logic            reg_rd_out,
  input  wire logic [7:0] reg_rdata_in
);
  // ----------------------------------------------------------------------
  // Byte accesses, one strobe cycle each
  // ----------------------------------------------------------------------
  initial begin
    reg_addr_out  = 8'h00;
    reg_wr_out    = 1'b0;
    reg_wdata_out = 8'h00;
    reg_rd_out    = 1'b0;
  end
  task automatic access(input logic [7:0] addr, input logic [7:0] data, input logic wr);
    @(posedge sys_clk_in);
    #1;
    reg_addr_out  = addr;
    reg_wdata_out = data;
    reg_wr_out    = wr;
    reg_rd_out    = !wr;
    @(posedge sys_clk_in);
    #1;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
    reg_addr_out  = ~addr;
    reg_wdata_out = ~data;
  endtask
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    access(addr, data, 1'b1);
  endtask
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    access(addr, 8'h00, 1'b0);
    data = reg_rdata_in;
  endtask
endmodule // als_host_model

/* dv/als_enable_and_timing_control_tb.sv */
// Testbench of the light sensor enable and timing control
`timescale 1ns/1ps
module als_enable_and_timing_control_tb;
  // ----------------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------------
  localparam int OSCD = 2;
  localparam int IPS  = 4;
  localparam int STEP = OSCD * IPS * 125 / 8;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        clk_en  = 1'b1;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [1:0]  seq_state;
  logic        osc_run;
  logic        integrating;
  logic        meas_done;
  logic [15:0] full_scale;
  logic [7:0]  rd_val;
  int          fails = 0;
  int          compares = 0;
  logic [7:0]  addrs [4] = '{8'h80, 8'h81, 8'h83, 8'h8D};
  logic [7:0]  fsv [5] = '{8'h00, 8'h01, 8'h3E, 8'h3F, 8'hFF};
  logic [15:0] fse [5] = '{16'h03FF, 16'h07FF, 16'hFBFF, 16'hFFFF, 16'hFFFF};
  always #4 sys_clk = ~sys_clk;
  als_enable_and_timing_control #(.OSC_DIV(OSCD), .INT_PER_STEP(IPS))
    als_enable_and_timing_control_inst (
    .sys_clk_in(sys_clk), .reset_n_in(reset_n), .clk_en_in(clk_en),
    .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata),
    .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .seq_state_out(seq_state),
    .osc_run_out(osc_run), .integrating_out(integrating), .meas_done_out(meas_done),
    .full_scale_out(full_scale));
  als_host_model als_host_model_inst (
    .sys_clk_in(sys_clk), .reg_addr_out(reg_addr), .reg_wr_out(reg_wr),
    .reg_wdata_out(reg_wdata), .reg_rd_out(reg_rd), .reg_rdata_in(reg_rdata));
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    als_host_model_inst.read_reg(addr, rd_val);
    check("reg_rdata", {8'h00, rd_val}, {8'h00, exp});
  endtask
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    als_host_model_inst.write_reg(addr, data);
  endtask
  task automatic len_chk(input logic [1:0] st, input int exp);
    int n;
    n = 0;
    for (int i = 0; i < 4000 && seq_state !== st; i++) tick();
    while (seq_state === st && n < 20000) begin
      tick();
      n++;
    end
    check("phase_len", (n >= exp - 2 && n <= exp + 2) ? 16'(exp) : 16'(n), 16'(exp));
  endtask
  task automatic after3_chk(input logic [1:0] st, input logic osc);
    repeat (3) tick();
    check("seq_state", {14'h0000, seq_state}, {14'h0000, st});
    check("osc_run", {15'h0000, osc_run}, {15'h0000, osc});
  endtask
  task automatic end_sim();
    $display("Compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    check("seq_state", {14'h0000, seq_state}, 16'h0000);
    check("full_scale", full_scale, 16'h03FF);
    rd_chk(8'h80, 8'h00);
    rd_chk(8'h81, 8'h00);
    rd_chk(8'h83, 8'h00);
    rd_chk(8'h8D, 8'h80);
    rd_chk(8'h90, 8'h00);
    $display("Test reset done");
    foreach (addrs[i]) begin
      wr(addrs[i], 8'h5A);
      rd_chk(addrs[i], 8'h5A);
    end
    wr(8'h84, 8'hFF);
    rd_chk(8'h84, 8'h00);
    wr(8'h80, 8'h00);
    wr(8'h8D, 8'h80);
    clk_en = 1'b0;
    wr(8'h83, 8'h77);
    clk_en = 1'b1;
    rd_chk(8'h83, 8'h5A);
    $display("Test readback done");
    foreach (fsv[i]) begin
      wr(8'h81, fsv[i]);
      repeat (3) tick();
      check("full_scale", full_scale, fse[i]);
    end
    $display("Test full scale done");
    wr(8'h80, 8'h01);
    after3_chk(2'd1, 1'b1);
    wr(8'h80, 8'h00);
    after3_chk(2'd0, 1'b0);
    $display("Test power done");
    wr(8'h81, 8'h01);
    wr(8'h83, 8'h00);
    wr(8'h80, 8'h0B);
    len_chk(2'd2, 2 * STEP);
    len_chk(2'd3, STEP);
    len_chk(2'd2, 2 * STEP);
    wr(8'h8D, 8'h84);
    len_chk(2'd2, 2 * STEP);
    len_chk(2'd3, 12 * STEP);
    $display("Test sequence done");
    wr(8'h80, 8'h03);
    for (int i = 0; i < 1000 && meas_done !== 1'b1; i++) tick();
    after3_chk(2'd2, 1'b1);
    wr(8'h80, 8'h01);
    after3_chk(2'd1, 1'b1);
    wr(8'h80, 8'h00);
    after3_chk(2'd0, 1'b0);
    $display("Test disables done");
    end_sim();
  end
endmodule // als_enable_and_timing_control_tb
bind als_enable_and_timing_control als_enable_and_timing_control_checker #(
  .OSC_DIV(OSC_DIV), .INT_PER_STEP(INT_PER_STEP)) als_enable_and_timing_control_checker_inst (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .seq_state_out(seq_state_out),
  .osc_run_out(osc_run_out), .integrating_out(integrating_out),
  .meas_done_out(meas_done_out), .full_scale_out(full_scale_out));
